// ### core/efc_pkg.sv
package efc_pkg;

   localparam int NUM_FLOWS = 8;
   localparam int NUM_CH = 2;
   localparam int AW = 9;
   localparam int DW = 32;
   localparam int BEW = DW / 8;
   localparam int MAC_W = 48;
   localparam int MAC_LO_W = 32;
   localparam int VID_W = 12;
   localparam int SID_W = 24;
   localparam int TPID_W = 16;
   localparam int NXT_W = 3;
   localparam int FIDX_W = 3;
   localparam int CNT_W = 32;

   // address decode: flow n (0..7) sits at byte 32*(n+1)
   localparam int FLOW_SHIFT = 5;
   localparam int WORD_SHIFT = 2;
   localparam logic [AW-1:0] REG_GLOBAL = 9'h000;
   localparam logic [AW-1:0] REG_ITAG = 9'h004;
   localparam logic [AW-1:0] REG_NXT_A = 9'h008;
   localparam logic [AW-1:0] REG_NXT_B = 9'h00c;
   localparam logic [AW-1:0] REG_STATUS = 9'h010;
   localparam logic [AW-1:0] REG_FRAMES = 9'h014;
   localparam logic [AW-1:0] REG_HITS = 9'h018;
   localparam logic [2:0] FW_CTL = 3'h0;
   localparam logic [2:0] FW_MAC_LO = 3'h1;
   localparam logic [2:0] FW_MAC_HI = 3'h2;
   localparam logic [2:0] FW_TAG1 = 3'h3;
   localparam logic [2:0] FW_TAG2 = 3'h4;
   localparam logic [2:0] FW_RANGE = 3'h5;

   localparam logic [TPID_W-1:0] C_TAG_ID = 16'h8100;
   localparam logic [TPID_W-1:0] LEN_LIMIT = 16'h0600;
   localparam logic [TPID_W-1:0] GTID_RST = 16'h0000;
   localparam logic [TPID_W-1:0] ITAG_ID_RST = 16'h0000;
   localparam logic [NXT_W-1:0] NXT_RST = 3'h0;

   localparam logic [1:0] TAGS_ONE = 2'h1;
   localparam logic [1:0] TAGS_TWO = 2'h2;
   localparam logic [1:0] RANGE_TAG1 = 2'h1;
   localparam logic [1:0] RANGE_TAG2 = 2'h2;
   localparam logic [1:0] MAC_DA = 2'h0;
   localparam logic [1:0] MAC_SA = 2'h1;
   localparam logic [1:0] MAC_EITHER = 2'h2;
   localparam int MK_FULL = 0;
   localparam int MK_UCAST = 1;
   localparam int MK_MCAST = 2;
   localparam int MAC_MSB = MAC_W - 1;

   typedef struct packed {
      logic grp_sel;
      logic [2:0] mac_kind;
      logic [1:0] mac_sel;
      logic [1:0] range_mode;
      logic verify;
      logic ft_mode;
      logic tag2_type;
      logic tag1_type;
      logic [1:0] tag_cnt;
      logic [NUM_CH-1:0] ch_sel;
      logic enable;
   } efc_ctl_t;

   // mask/match or high/low pair, upper field in [23:12]
   typedef struct packed {
      logic [VID_W-1:0] hi;
      logic [VID_W-1:0] lo;
   } efc_pair_t;

   typedef struct packed {
      efc_ctl_t ctl;
      logic [MAC_W-1:0] mac;
      efc_pair_t tag1;
      efc_pair_t tag2;
      efc_pair_t range;
   } efc_flow_cfg_t;

   localparam efc_flow_cfg_t FLOW_RST = '0;

   typedef struct packed {
      logic pbb_en;
      logic [TPID_W-1:0] gtid;
   } efc_glb_t;

   typedef struct packed {
      logic valid;
      logic [0:0] channel;
      logic [MAC_W-1:0] da;
      logic [MAC_W-1:0] sa;
      logic [1:0] tag_cnt;
      logic [TPID_W-1:0] tag1_tpid;
      logic [VID_W-1:0] tag1_vid;
      logic [TPID_W-1:0] tag2_tpid;
      logic [VID_W-1:0] tag2_vid;
      logic [SID_W-1:0] isid;
      logic [TPID_W-1:0] etype_len;
      logic llc_snap;
   } efc_frame_t;

endpackage : efc_pkg

// ### core/efc_flow_match.sv
`timescale 1ns/1ps
`default_nettype none

module efc_flow_match (
   input var efc_pkg::efc_flow_cfg_t cfg, // one flow entry
   input var efc_pkg::efc_frame_t frm, // parsed header
   input wire logic [efc_pkg::TPID_W-1:0] gtid, // global s/b-tag id
   input wire logic [efc_pkg::TPID_W-1:0] itag_id, // i-tag id
   input wire logic pbb, // backbone bridging on
   output logic hit // entry matches frame
);

   logic [efc_pkg::TPID_W-1:0] exp1;
   logic [efc_pkg::TPID_W-1:0] exp2;
   logic v1_ok;
   logic v2_ok;
   logic [efc_pkg::VID_W-1:0] rvid;
   logic rng_ok;
   logic tags_ok;
   logic is_len;
   logic ft_ok;
   logic addr_ok;

   function automatic logic mac_ok(input logic [efc_pkg::MAC_W-1:0] a,
                                   input efc_pkg::efc_flow_cfg_t c);
      mac_ok = (c.ctl.mac_kind[efc_pkg::MK_FULL] && a == c.mac) ||
               (c.ctl.mac_kind[efc_pkg::MK_UCAST] && !a[efc_pkg::MAC_MSB]) ||
               (c.ctl.mac_kind[efc_pkg::MK_MCAST] && a[efc_pkg::MAC_MSB]) ||
               (c.ctl.mac_kind == '0);
   endfunction : mac_ok

   always_comb begin
      exp1 = cfg.ctl.tag1_type ? gtid : efc_pkg::C_TAG_ID;
      exp2 = cfg.ctl.tag2_type ? gtid : efc_pkg::C_TAG_ID;
      v1_ok = ((frm.tag1_vid ^ cfg.tag1.lo) & cfg.tag1.hi) == '0;
      v2_ok = ((frm.tag2_vid ^ cfg.tag2.lo) & cfg.tag2.hi) == '0;
      rvid = (cfg.ctl.range_mode == efc_pkg::RANGE_TAG2) ?
             frm.tag2_vid : frm.tag1_vid;
      rng_ok = !(cfg.ctl.range_mode == efc_pkg::RANGE_TAG1 ||
                 cfg.ctl.range_mode == efc_pkg::RANGE_TAG2) ||
               (rvid >= cfg.range.lo && rvid <= cfg.range.hi);
      if (pbb) begin
         // limits carry the service id here, the i-tag is always checked
         tags_ok = frm.isid == {cfg.range.hi, cfg.range.lo};
         if (cfg.ctl.tag1_type) begin
            tags_ok = tags_ok && frm.tag_cnt == efc_pkg::TAGS_ONE &&
                      frm.tag1_tpid == itag_id;
         end else begin
            tags_ok = tags_ok && frm.tag_cnt == efc_pkg::TAGS_TWO &&
                      frm.tag1_tpid == gtid && frm.tag2_tpid == itag_id &&
                      (!cfg.ctl.verify || v1_ok);
         end
      end else if (cfg.ctl.verify) begin
         tags_ok = frm.tag_cnt == cfg.ctl.tag_cnt && rng_ok &&
                   (frm.tag_cnt < efc_pkg::TAGS_ONE ||
                    (frm.tag1_tpid == exp1 && v1_ok)) &&
                   (frm.tag_cnt < efc_pkg::TAGS_TWO ||
                    (frm.tag2_tpid == exp2 && v2_ok));
      end else begin
         tags_ok = 1'b1;
      end
      is_len = frm.etype_len < efc_pkg::LEN_LIMIT;
      ft_ok = cfg.ctl.ft_mode ? (is_len == frm.llc_snap) :
              (!is_len && !frm.llc_snap);
      unique case (cfg.ctl.mac_sel)
         efc_pkg::MAC_DA: addr_ok = mac_ok(frm.da, cfg);
         efc_pkg::MAC_SA: addr_ok = mac_ok(frm.sa, cfg);
         efc_pkg::MAC_EITHER: addr_ok = mac_ok(frm.da, cfg) ||
                                         mac_ok(frm.sa, cfg);
         default: addr_ok = 1'b0;
      endcase
      hit = cfg.ctl.enable && cfg.ctl.ch_sel[frm.channel] &&
            tags_ok && ft_ok && addr_ok;
   end

endmodule : efc_flow_match

`default_nettype wire

// ### core/efc_classifier.sv
// Function
// - classify frames by vlan tags and mac address over many flow entries
// - each flow has an enable and one channel select bit per channel
// - two-bit field gives expected vlan tag count zero, one or two
// - without bridging first tag type picks 0x8100 or global id
// - with bridging first tag type picks s/b-tag plus i-tag or i-tag
// - second tag type like first; with bridging second tag is i-tag
// - frame type mode 0 accepts only ethertype frames without llc/snap
// - mode 1: length below 0x0600 needs llc/snap, otherwise none
// - verify off: tags not value checked, i-tag still checked in bridging
// - verify on: tag count and tag values are checked
// - range mode selects no range, first tag or second tag
// - address compared to destination, source or either; 3 never matches
// - address kind bits allow full, unicast and multicast in any mix
// - unicast and multicast look only at address msb
// - each flow holds 12-bit match and mask for both tags
// - 12-bit high and low limits bound the selected tag id
// - with bridging the limits form the expected i-tag service id
// - per-flow group bit maps a flow to next-protocol set a or b
// - two identical next-protocol sets, a and b
// - eight flows split between the two sets in any way
// - mask bit 1 compares the match bit, 0 makes it a wildcard
// - range limits are inclusive
// - global 16-bit id defines s-tags and b-tags
// - bridging exists only in the first comparator
//
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module efc_classifier #(
   parameter bit FIRST_COMPARATOR = 1'b1
) (
   input wire logic clk, // 25 MHz clock
   input wire logic srst, // sync reset, active high
   input wire logic [efc_pkg::AW-1:0] avs_address, // byte address
   input wire logic avs_read, // read request
   input wire logic avs_write, // write request
   input wire logic [efc_pkg::DW-1:0] avs_writedata, // write data
   input wire logic [efc_pkg::BEW-1:0] avs_byteenable, // byte lanes
   output logic [efc_pkg::DW-1:0] avs_readdata, // read data
   output logic avs_waitrequest, // stall
   input var efc_pkg::efc_frame_t frm_in, // parsed header, one-cycle valid
   output logic res_valid, // result pulse
   output logic [efc_pkg::NUM_FLOWS-1:0] res_hit, // matched flows
   output logic res_any, // some flow matched
   output logic [efc_pkg::FIDX_W-1:0] res_flow, // lowest matched flow
   output logic res_group_b, // winner uses set b
   output logic [efc_pkg::NXT_W-1:0] res_next_cmp // next comparator
);

   efc_pkg::efc_flow_cfg_t cfg_ff [efc_pkg::NUM_FLOWS];
   efc_pkg::efc_glb_t glb_ff;
   logic [efc_pkg::TPID_W-1:0] itag_id_ff;
   logic [efc_pkg::NXT_W-1:0] nxt_a_ff;
   logic [efc_pkg::NXT_W-1:0] nxt_b_ff;
   logic [efc_pkg::CNT_W-1:0] frames_ff;
   logic [efc_pkg::CNT_W-1:0] hits_ff;
   logic rd_ack_ff;
   logic [efc_pkg::DW-1:0] rdata_ff;
   logic res_valid_ff;
   logic [efc_pkg::NUM_FLOWS-1:0] res_hit_ff;
   logic res_any_ff;
   logic [efc_pkg::FIDX_W-1:0] res_flow_ff;
   logic res_group_b_ff;
   logic [efc_pkg::NXT_W-1:0] res_next_cmp_ff;

   logic pbb;
   logic [efc_pkg::NUM_FLOWS-1:0] hit;
   logic [efc_pkg::FIDX_W-1:0] nxt_res_flow;
   logic nxt_res_any;
   logic [efc_pkg::AW-efc_pkg::FLOW_SHIFT-1:0] fsel;
   logic [efc_pkg::FIDX_W-1:0] fidx;
   logic [2:0] fword;
   logic is_flow;
   logic mapped;
   logic [efc_pkg::DW-1:0] rd_word;
   logic [efc_pkg::DW-1:0] wmask;
   logic [efc_pkg::DW-1:0] merged;
   logic wr_en;
   logic clr_cnt;

   // bridging is hard-disabled unless this is the first comparator
   assign pbb = FIRST_COMPARATOR && glb_ff.pbb_en;

   genvar gi;
   generate
      for (gi = 0; gi < efc_pkg::NUM_FLOWS; gi++) begin : g_flow
         efc_flow_match u_match (
            .cfg(cfg_ff[gi]),
            .frm(frm_in),
            .gtid(glb_ff.gtid),
            .itag_id(itag_id_ff),
            .pbb(pbb),
            .hit(hit[gi])
         );
      end
   endgenerate

   // lowest-numbered matching flow wins the next-protocol set
   always_comb begin
      nxt_res_flow = '0;
      nxt_res_any = 1'b0;
      for (int i = efc_pkg::NUM_FLOWS - 1; i >= 0; i--) begin
         if (hit[i]) begin
            nxt_res_flow = efc_pkg::FIDX_W'(i);
            nxt_res_any = 1'b1;
         end
      end
   end

   // register decode
   always_comb begin
      fsel = avs_address[efc_pkg::AW-1:efc_pkg::FLOW_SHIFT];
      fidx = efc_pkg::FIDX_W'(fsel - 1'b1);
      fword = avs_address[efc_pkg::FLOW_SHIFT-1:efc_pkg::WORD_SHIFT];
      is_flow = fsel != '0 && fsel <= efc_pkg::NUM_FLOWS;
      mapped = 1'b1;
      rd_word = '0;
      if (is_flow) begin
         unique case (fword)
            efc_pkg::FW_CTL: rd_word = efc_pkg::DW'(cfg_ff[fidx].ctl);
            efc_pkg::FW_MAC_LO:
               rd_word = cfg_ff[fidx].mac[efc_pkg::MAC_LO_W-1:0];
            efc_pkg::FW_MAC_HI: rd_word = efc_pkg::DW'(
               cfg_ff[fidx].mac[efc_pkg::MAC_W-1:efc_pkg::MAC_LO_W]);
            efc_pkg::FW_TAG1: rd_word = efc_pkg::DW'(cfg_ff[fidx].tag1);
            efc_pkg::FW_TAG2: rd_word = efc_pkg::DW'(cfg_ff[fidx].tag2);
            efc_pkg::FW_RANGE: rd_word = efc_pkg::DW'(cfg_ff[fidx].range);
            default: mapped = 1'b0;
         endcase
      end else begin
         unique case (avs_address)
            efc_pkg::REG_GLOBAL: rd_word = efc_pkg::DW'(glb_ff);
            efc_pkg::REG_ITAG: rd_word = efc_pkg::DW'(itag_id_ff);
            efc_pkg::REG_NXT_A: rd_word = efc_pkg::DW'(nxt_a_ff);
            efc_pkg::REG_NXT_B: rd_word = efc_pkg::DW'(nxt_b_ff);
            efc_pkg::REG_STATUS: rd_word = efc_pkg::DW'({res_any_ff,
                                                         res_hit_ff});
            efc_pkg::REG_FRAMES: rd_word = frames_ff;
            efc_pkg::REG_HITS: rd_word = hits_ff;
            default: mapped = 1'b0;
         endcase
      end
      for (int b = 0; b < efc_pkg::BEW; b++) begin
         wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
      end
      merged = (rd_word & ~wmask) | (avs_writedata & wmask);
      wr_en = avs_write && mapped;
      clr_cnt = wr_en && !is_flow && (avs_address == efc_pkg::REG_FRAMES ||
                                       avs_address == efc_pkg::REG_HITS);
   end

   // writes never stall; reads stall one cycle while data is registered
   assign avs_waitrequest = avs_read && !rd_ack_ff;
   assign avs_readdata = rdata_ff;

   always_ff @(posedge clk) begin
      if (srst) begin
         rd_ack_ff <= 1'b0;
         rdata_ff <= '0;
      end else begin
         rd_ack_ff <= avs_read && !rd_ack_ff;
         if (avs_read && !rd_ack_ff) begin
            rdata_ff <= rd_word;
         end
      end
   end

   // per-flow entries
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int i = 0; i < efc_pkg::NUM_FLOWS; i++) begin
            cfg_ff[i] <= efc_pkg::FLOW_RST;
         end
      end else if (wr_en && is_flow) begin
         unique case (fword)
            efc_pkg::FW_CTL: cfg_ff[fidx].ctl <=
               merged[$bits(efc_pkg::efc_ctl_t)-1:0];
            efc_pkg::FW_MAC_LO:
               cfg_ff[fidx].mac[efc_pkg::MAC_LO_W-1:0] <= merged;
            efc_pkg::FW_MAC_HI:
               cfg_ff[fidx].mac[efc_pkg::MAC_W-1:efc_pkg::MAC_LO_W] <=
                  merged[efc_pkg::MAC_W-efc_pkg::MAC_LO_W-1:0];
            efc_pkg::FW_TAG1: cfg_ff[fidx].tag1 <=
               merged[$bits(efc_pkg::efc_pair_t)-1:0];
            efc_pkg::FW_TAG2: cfg_ff[fidx].tag2 <=
               merged[$bits(efc_pkg::efc_pair_t)-1:0];
            efc_pkg::FW_RANGE: cfg_ff[fidx].range <=
               merged[$bits(efc_pkg::efc_pair_t)-1:0];
            default: ;
         endcase
      end
   end

   // global settings and the two next-protocol sets
   always_ff @(posedge clk) begin
      if (srst) begin
         glb_ff <= {1'b0, efc_pkg::GTID_RST};
         itag_id_ff <= efc_pkg::ITAG_ID_RST;
         nxt_a_ff <= efc_pkg::NXT_RST;
         nxt_b_ff <= efc_pkg::NXT_RST;
      end else if (wr_en && !is_flow) begin
         unique case (avs_address)
            efc_pkg::REG_GLOBAL:
               glb_ff <= merged[$bits(efc_pkg::efc_glb_t)-1:0];
            efc_pkg::REG_ITAG: itag_id_ff <= merged[efc_pkg::TPID_W-1:0];
            efc_pkg::REG_NXT_A:
               nxt_a_ff <= merged[efc_pkg::NXT_W-1:0];
            efc_pkg::REG_NXT_B:
               nxt_b_ff <= merged[efc_pkg::NXT_W-1:0];
            default: ;
         endcase
      end
   end

   // statistics; a clear in the same cycle as a counting frame restarts the count at 1
   always_ff @(posedge clk) begin
      if (srst) begin
         frames_ff <= '0;
         hits_ff <= '0;
      end else begin
         if (frm_in.valid) begin
            frames_ff <= clr_cnt ? efc_pkg::CNT_W'(1) : frames_ff + 1'b1;
         end else if (clr_cnt) begin
            frames_ff <= '0;
         end
         if (frm_in.valid && nxt_res_any) begin
            hits_ff <= clr_cnt ? efc_pkg::CNT_W'(1) : hits_ff + 1'b1;
         end else if (clr_cnt) begin
            hits_ff <= '0;
         end
      end
   end

   // classification result, one cycle after the header
   always_ff @(posedge clk) begin
      if (srst) begin
         res_valid_ff <= 1'b0;
         res_hit_ff <= '0;
         res_any_ff <= 1'b0;
         res_flow_ff <= '0;
         res_group_b_ff <= 1'b0;
         res_next_cmp_ff <= efc_pkg::NXT_RST;
      end else begin
         res_valid_ff <= frm_in.valid;
         if (frm_in.valid) begin
            res_hit_ff <= hit;
            res_any_ff <= nxt_res_any;
            res_flow_ff <= nxt_res_flow;
            res_group_b_ff <= nxt_res_any &&
                              cfg_ff[nxt_res_flow].ctl.grp_sel;
            res_next_cmp_ff <= (nxt_res_any &&
                                cfg_ff[nxt_res_flow].ctl.grp_sel) ?
                               nxt_b_ff : nxt_a_ff;
         end
      end
   end

   assign res_valid = res_valid_ff;
   assign res_hit = res_hit_ff;
   assign res_any = res_any_ff;
   assign res_flow = res_flow_ff;
   assign res_group_b = res_group_b_ff;
   assign res_next_cmp = res_next_cmp_ff;

   // checks on the bus, the result and flow 0
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   sequence s_rd_start;
      avs_read && avs_waitrequest;
   endsequence
   sequence s_rd_held;
      avs_read && $stable(avs_address);
   endsequence

   AST_RD_ONE_WAIT: assert property (
      s_rd_start ##1 s_rd_held |-> !avs_waitrequest
   ) else $error("read not answered after one wait cycle");

   AST_RESULT_PULSE: assert property (
      frm_in.valid |=> res_valid && res_hit == $past(hit)
   ) else $error("result did not follow the header");

   AST_DISABLED: assert property (
      frm_in.valid && (!cfg_ff[0].ctl.enable ||
                       !cfg_ff[0].ctl.ch_sel[frm_in.channel]) |=> !res_hit[0]
   ) else $error("disabled or unselected flow matched");

   AST_FT_MODE0: assert property (
      frm_in.valid && !cfg_ff[0].ctl.ft_mode &&
      (frm_in.etype_len < efc_pkg::LEN_LIMIT || frm_in.llc_snap)
      |=> !res_hit[0]
   ) else $error("type 1 or snap frame matched in mode 0");

   AST_FT_MODE1: assert property (
      frm_in.valid && cfg_ff[0].ctl.ft_mode &&
      ((frm_in.etype_len < efc_pkg::LEN_LIMIT) != frm_in.llc_snap)
      |=> !res_hit[0]
   ) else $error("llc/snap presence disagrees with length field");

   AST_TAG_COUNT: assert property (
      frm_in.valid && !pbb && cfg_ff[0].ctl.verify &&
      frm_in.tag_cnt != cfg_ff[0].ctl.tag_cnt |=> !res_hit[0]
   ) else $error("wrong tag count matched");

   AST_TAG1_MASK: assert property (
      frm_in.valid && !pbb && cfg_ff[0].ctl.verify &&
      frm_in.tag_cnt >= efc_pkg::TAGS_ONE &&
      ((frm_in.tag1_vid ^ cfg_ff[0].tag1.lo) & cfg_ff[0].tag1.hi) != '0
      |=> !res_hit[0]
   ) else $error("masked tag mismatch matched");

   AST_RANGE_HIGH: assert property (
      frm_in.valid && !pbb && cfg_ff[0].ctl.verify &&
      cfg_ff[0].ctl.range_mode == efc_pkg::RANGE_TAG1 &&
      frm_in.tag1_vid > cfg_ff[0].range.hi |=> !res_hit[0]
   ) else $error("tag above range matched");

   AST_PBB_SID: assert property (
      frm_in.valid && pbb &&
      frm_in.isid != {cfg_ff[0].range.hi, cfg_ff[0].range.lo}
      |=> !res_hit[0]
   ) else $error("wrong service id matched");

   AST_ADDR_RSVD: assert property (
      frm_in.valid && cfg_ff[0].ctl.mac_sel == 2'h3 |=> !res_hit[0]
   ) else $error("reserved address select matched");

   AST_GROUP: assert property (
      res_valid && res_any |->
      res_next_cmp == (res_group_b ? nxt_b_ff : nxt_a_ff) ||
      $past(nxt_a_ff) != nxt_a_ff || $past(nxt_b_ff) != nxt_b_ff
   ) else $error("next comparator not from winner's set");

endmodule : efc_classifier

`default_nettype wire

// ### tb/efc_frame_src.sv
`timescale 1ns/1ps
`default_nettype none

module efc_frame_src (
   input wire logic clk, // clock
   input wire logic srst, // sync reset
   input var efc_pkg::efc_frame_t nxt, // frame to send, valid asks
   output var efc_pkg::efc_frame_t frm // frame toward classifier
);
   // between frames every field but valid flips so stale data never looks held
   always_ff @(posedge clk) begin
      if (srst) begin
         frm <= '0;
      end else if (nxt.valid) begin
         frm <= nxt;
      end else begin
         frm <= {1'b0, ~frm[$bits(efc_pkg::efc_frame_t)-2:0]};
      end
   end
endmodule : efc_frame_src

`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   logic clk;
   logic srst = 1'b1;
   logic [8:0] avs_address = 9'h000;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [31:0] avs_readdata, rdv;
   logic avs_waitrequest, res_valid, res_any, res_group_b;
   logic [7:0] res_hit;
   logic [2:0] res_flow, res_next_cmp;
   efc_pkg::efc_frame_t nxt = '0;
   efc_pkg::efc_frame_t frm;
   int failures = 0;
   int n_tests = 0;
   int cyc = 0;
   // sel, kind, expected hit
   localparam logic [5:0] ADDR_TAB [8] = '{6'h13, 6'h02, 6'h23, 6'h32,
      6'h05, 6'h14, 6'h19, 6'h0d};

   efc_classifier #(.FIRST_COMPARATOR(1'b1)) u_dut (.clk(clk), .srst(srst),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .frm_in(frm),
      .res_valid(res_valid), .res_hit(res_hit), .res_any(res_any),
      .res_flow(res_flow), .res_group_b(res_group_b),
      .res_next_cmp(res_next_cmp));
   efc_frame_src u_src (.clk(clk), .srst(srst), .nxt(nxt), .frm(frm));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task results();
      if (failures == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : results

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         results();
      end
   end

   task chk(string nm, logic [47:0] s, logic [47:0] e);
      n_tests++;
      if (s !== e) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task wr(logic [8:0] a, logic [31:0] d);
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      avs_write <= 1'b0;
   endtask : wr

   task rd(logic [8:0] a);
      @(posedge clk);
      avs_address <= a;
      avs_read <= 1'b1;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rdv = avs_readdata;
      avs_read <= 1'b0;
   endtask : rd

   task fr(efc_pkg::efc_frame_t f, logic [7:0] e);
      f.valid = 1'b1;
      @(posedge clk);
      nxt <= f;
      @(posedge clk);
      nxt.valid <= 1'b0;
      @(negedge clk);
      @(negedge clk);
      chk("res_valid", res_valid, 1'b1);
      chk("res_hit", res_hit, e);
      @(negedge clk);
      chk("res_valid_end", res_valid, 1'b0);
   endtask : fr

   function automatic logic [31:0] ctl(logic [1:0] tg, logic t1, logic ft,
      logic vf, logic [1:0] rm, logic [1:0] ms, logic [2:0] mk);
      return {16'h0, mk, ms, rm, vf, ft, 1'b0, t1, tg, 2'h1, 1'b1};
   endfunction : ctl

   function automatic efc_pkg::efc_frame_t bf();
      efc_pkg::efc_frame_t f;
      f = '0;
      f.da = 48'h0200_0000_0001;
      f.sa = 48'h8000_0000_0002;
      f.tag_cnt = 2'h1;
      f.tag1_tpid = efc_pkg::C_TAG_ID;
      f.tag1_vid = 12'h123;
      f.etype_len = 16'h0800;
      return f;
   endfunction : bf

   task cfg(int n, logic [31:0] c, logic [47:0] m, logic [23:0] t1,
      logic [23:0] rg);
      logic [8:0] b;
      b = 9'(32 * (n + 1));
      wr(b, c);
      wr(b + 9'h004, m[31:0]);
      wr(b + 9'h008, {16'h0, m[47:32]});
      wr(b + 9'h00c, {8'h0, t1});
      wr(b + 9'h010, 32'h0);
      wr(b + 9'h014, {8'h0, rg});
   endtask : cfg

   task t_regs();
      rd(9'h020);
      chk("ctl_rst", rdv, 32'h0);
      wr(9'h048, 32'hffffffff);
      rd(9'h048);
      chk("mac_hi", rdv, 32'h0000ffff);
      avs_byteenable <= 4'h1;
      wr(9'h048, 32'h0);
      avs_byteenable <= 4'hf;
      rd(9'h048);
      chk("mac_be", rdv, 32'h0000ff00);
      wr(9'h02c, 32'hffffffff);
      rd(9'h02c);
      chk("tag1", rdv, 32'h00ffffff);
      wr(9'h03c, 32'h00001234);
      rd(9'h03c);
      chk("unmapped", rdv, 32'h0);
   endtask : t_regs

   task t_basic();
      efc_pkg::efc_frame_t f, g;
      f = bf();
      cfg(0, ctl(2'h1, 0, 0, 1, 2'h0, 2'h0, 3'h1), f.da, 24'hfff123, 24'h0);
      fr(f, 8'h01);
      g = f;
      g.tag1_vid = 12'h124;
      fr(g, 8'h00);
      g = f;
      g.channel = 1'b1;
      fr(g, 8'h00);
      g = f;
      g.tag_cnt = 2'h2;
      fr(g, 8'h00);
      g = f;
      g.da[0] = 1'b0;
      fr(g, 8'h00);
      g = f;
      g.tag1_tpid = 16'h88a8;
      fr(g, 8'h00);
      wr(9'h000, 32'h000088a8);
      wr(9'h020, ctl(2'h1, 1, 0, 1, 2'h0, 2'h0, 3'h1));
      fr(g, 8'h01);
      fr(f, 8'h00);
      wr(9'h020, ctl(2'h1, 1, 0, 0, 2'h0, 2'h0, 3'h1));
      g.tag1_vid = 12'h124;
      fr(g, 8'h01);
      wr(9'h020, 32'h0);
      fr(f, 8'h00);
   endtask : t_basic

   task t_range();
      efc_pkg::efc_frame_t f;
      f = bf();
      cfg(0, ctl(2'h1, 0, 0, 1, 2'h1, 2'h0, 3'h0), 48'h0, 24'h0, 24'h020010);
      f.tag1_vid = 12'h00f;
      fr(f, 8'h00);
      f.tag1_vid = 12'h010;
      fr(f, 8'h01);
      f.tag1_vid = 12'h020;
      fr(f, 8'h01);
      f.tag1_vid = 12'h021;
      fr(f, 8'h00);
      wr(9'h020, ctl(2'h1, 0, 0, 1, 2'h0, 2'h0, 3'h0));
      fr(f, 8'h01);
      wr(9'h02c, 32'h000f0020);
      f.tag1_vid = 12'h02f;
      fr(f, 8'h01);
      f.tag1_vid = 12'h03f;
      fr(f, 8'h00);
      wr(9'h020, ctl(2'h2, 0, 0, 1, 2'h2, 2'h0, 3'h0));
      f.tag1_vid = 12'h020;
      f.tag_cnt = 2'h2;
      f.tag2_tpid = efc_pkg::C_TAG_ID;
      f.tag2_vid = 12'h021;
      fr(f, 8'h00);
      f.tag2_vid = 12'h015;
      fr(f, 8'h01);
   endtask : t_range

   task t_ftype();
      efc_pkg::efc_frame_t f;
      f = bf();
      f.tag_cnt = 2'h0;
      cfg(0, ctl(2'h0, 0, 0, 1, 2'h0, 2'h0, 3'h0), 48'h0, 24'h0, 24'h0);
      fr(f, 8'h01);
      f.etype_len = 16'h05ff;
      fr(f, 8'h00);
      f.llc_snap = 1'b1;
      fr(f, 8'h00);
      wr(9'h020, ctl(2'h0, 0, 1, 1, 2'h0, 2'h0, 3'h0));
      fr(f, 8'h01);
      f.etype_len = 16'h0600;
      fr(f, 8'h00);
      f.llc_snap = 1'b0;
      fr(f, 8'h01);
      f.etype_len = 16'h05ff;
      fr(f, 8'h00);
   endtask : t_ftype

   task t_addr();
      efc_pkg::efc_frame_t f;
      f = bf();
      cfg(0, ctl(2'h0, 0, 0, 0, 2'h0, 2'h0, 3'h0), f.sa, 24'h0, 24'h0);
      for (int i = 0; i < 8; i++) begin
         wr(9'h020, ctl(0, 0, 0, 0, 0, ADDR_TAB[i][5:4], ADDR_TAB[i][3:1]));
         fr(f, {7'h0, ADDR_TAB[i][0]});
      end
   endtask : t_addr

   task t_pbb();
      efc_pkg::efc_frame_t f;
      f = bf();
      f.tag1_tpid = 16'h88e7;
      f.isid = 24'habcdef;
      wr(9'h000, 32'h000188a8);
      wr(9'h004, 32'h000088e7);
      cfg(0, ctl(2'h1, 1, 0, 0, 2'h0, 2'h0, 3'h0), 48'h0, 24'h0, 24'habcdef);
      fr(f, 8'h01);
      f.isid = 24'habcdee;
      fr(f, 8'h00);
      wr(9'h020, ctl(2'h2, 0, 0, 0, 2'h0, 2'h0, 3'h0));
      f.isid = 24'habcdef;
      f.tag_cnt = 2'h2;
      f.tag1_tpid = 16'h88a8;
      f.tag2_tpid = 16'h88e7;
      fr(f, 8'h01);
      f.tag_cnt = 2'h1;
      fr(f, 8'h00);
      wr(9'h000, 32'h000088a8);
   endtask : t_pbb

   task t_group();
      efc_pkg::efc_frame_t f;
      f = bf();
      wr(9'h014, 32'h0);
      wr(9'h008, 32'h00000003);
      wr(9'h00c, 32'h00000005);
      cfg(0, ctl(2'h1, 0, 0, 0, 2'h0, 2'h0, 3'h0), 48'h0, 24'h0, 24'h0);
      cfg(1, ctl(2'h1, 0, 0, 0, 2'h0, 2'h0, 3'h0) | 32'h00010000, 48'h0,
         24'h0, 24'h0);
      fr(f, 8'h03);
      chk("flow", res_flow, 3'h0);
      chk("any", res_any, 1'b1);
      chk("next", res_next_cmp, 3'h3);
      rd(9'h010);
      chk("status", rdv, 32'h00000103);
      wr(9'h020, 32'h0);
      fr(f, 8'h02);
      chk("grp_b", res_group_b, 1'b1);
      chk("next_b", res_next_cmp, 3'h5);
      rd(9'h014);
      chk("frames", rdv, 32'h00000002);
      rd(9'h018);
      chk("hits", rdv, 32'h00000002);
   endtask : t_group

   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      t_regs();
      t_basic();
      t_range();
      t_ftype();
      t_addr();
      t_pbb();
      t_group();
      results();
   end
endmodule : tb_top

`default_nettype wire
